// ### dv/ctm_monitor.sv
// Assertion checker for the channel mapping block
`timescale 1ns/1ns
`default_nettype none
module ctm_monitor
    import ctm_pkg::*;
#(parameter int unsigned NUM_CHAN = CHAN_W) (
    // Clock and reset
    input wire logic                        sys_clk,
    input wire logic                        rst_b,
    // Bus
    input wire logic [ctm_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic [ctm_pkg::DATA_W-1:0]  s_axi_wdata,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic [ctm_pkg::ADDR_W-1:0]  s_axi_araddr,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [ctm_pkg::DATA_W-1:0]  s_axi_rdata,
    input wire logic [1:0]                  s_axi_rresp,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    // Events
    input wire logic [NUM_CHAN-1:0]         channelEvent
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rdTake = s_axi_arvalid && s_axi_arready;
    property pPulse;
        logic [3:0] d;
        (wrBoth && s_axi_awaddr == OFS_PULSE, d = s_axi_wdata[3:0]) |-> ##2 ((channelEvent[3:0] & d) == d);
    endproperty
    a_pulse_event: assert property (pPulse) else $error("pulse missing");
    a_pulse_reads: assert property (rdTake && s_axi_araddr == OFS_PULSE |=> s_axi_rdata == 32'h0)
        else $error("pulse reg not clear");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
        else $error("upper bits set");
    a_read_late: assert property (rdTake |=> s_axi_rvalid) else $error("read late");
    a_write_late: assert property (wrBoth |=> s_axi_bvalid) else $error("write late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken early");
    a_bad_read: assert property (rdTake && s_axi_araddr > OFS_STATUS |=> s_axi_rresp == RESP_SLVERR)
        else $error("unmapped okay");
    c_pulse: cover property (wrBoth && s_axi_awaddr == OFS_PULSE);
    c_bad: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_event: cover property (channelEvent != '0);
endmodule : ctm_monitor
bind ctm_channel_mapping ctm_monitor #(.NUM_CHAN(NUM_CHAN)) u_mon (.sys_clk(sys_clk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .channelEvent(channelEvent));
`default_nettype wire

// ### dv/ctm_trig_src.sv
// Trigger source and matrix-side catcher
`timescale 1ns/1ns
`default_nettype none
module ctm_trig_src (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // Trigger side
    input wire logic [2:0]  level,
    output var logic [2:0]  triggerIn,
    // Matrix side
    input wire logic [3:0]  channelEvent,
    output var logic [3:0]  seen
);
    always_ff @(posedge sys_clk) triggerIn <= level;
    // Sticky catch, as a handshake stretcher would hold it
    always_ff @(posedge sys_clk) seen <= !rst_b ? 4'h0 : (seen | channelEvent);
endmodule : ctm_trig_src
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the channel mapping block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ctm_pkg::*;
    logic sys_clk, rst_b, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] trigLevel, triggerIn;
    logic [3:0] channelEvent, seen, e[3];
    logic [33:0] rdq[$];
    logic [1:0] bq[$];
    int miscompares, checks, seed, i;
    ctm_channel_mapping DUT (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .triggerIn(triggerIn), .channelEvent(channelEvent));
    ctm_trig_src u_src (.sys_clk(sys_clk), .rst_b(rst_b), .level(trigLevel), .triggerIn(triggerIn),
        .channelEvent(channelEvent), .seen(seen));
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic test_done;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // Ready is raised only after valid shows, so the hold window is exercised
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        bq.push_back(r);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid && bready) begin bready <= 0; break; end
            else if (bvalid) bready <= 1;
        end
        if (n == 50) begin miscompares++; test_done(); end
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [33:0] x);
        int n;
        rdq.push_back(x);
        araddr <= a; arvalid <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid && rready) begin rready <= 0; break; end
            else if (rvalid) rready <= 1;
        end
        if (n == 50) begin miscompares++; test_done(); end
    endtask : rd
    // Result watcher: oldest expectation against each answer
    always @(posedge sys_clk) begin
        if (rvalid && rready) cmp({rresp, rdata}, rdq.pop_front());
        if (bvalid && bready) cmp(34'(bresp), 34'(bq.pop_front()));
    end
    // The pulse ends on the edge that takes the write answer, so a side branch watches from the edge that takes address and data
    task automatic pulse(input logic [3:0] p, input logic [3:0] bg);
        int n;
        fork
            wr(OFS_PULSE, {28'($random(seed)), p}, RESP_OKAY);
            begin
                for (n = 0; n < 50; n++) begin
                    @(posedge sys_clk);
                    if (awvalid && awready && wvalid && wready) break;
                end
                if (n == 50) miscompares++;
                @(posedge sys_clk);
                cmp(34'(channelEvent), 34'(bg));
                @(posedge sys_clk);
                cmp(34'(channelEvent), 34'(p | bg));
                @(posedge sys_clk);
                cmp(34'(channelEvent), 34'(bg));
            end
        join
    endtask : pulse
    initial begin
        seed = 71513; rst_b = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; trigLevel = 0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1;
        for (i = 0; i < 5; i++) rd(6'(4 * i), 34'h0);
        wr(OFS_INEN1, {28'($random(seed)), 4'h5}, RESP_OKAY);
        rd(OFS_INEN1, 34'h5);
        for (i = 0; i < 3; i++) pulse(4'(12'h05a >> (4 * i)), 4'h0);
        rd(6'h3c, {RESP_SLVERR, 32'h0});
        wr(6'h3c, 32'hf, RESP_SLVERR);
        wr(OFS_CONTROL, 32'h1, RESP_OKAY);
        for (i = 0; i < 3; i++) begin
            e[i] = 4'($random(seed)) | 4'h1;
            wr(6'(OFS_INEN0 + 4 * i), {28'($random(seed)), e[i]}, RESP_OKAY);
            trigLevel <= 3'(1 << i);
            repeat (5) @(posedge sys_clk);
            rd(OFS_STATUS, 34'(e[i]));
        end
        wr(OFS_CONTROL, 32'h0, RESP_OKAY);
        repeat (4) @(posedge sys_clk);
        rd(OFS_STATUS, 34'h0);
        pulse(4'h6, 4'h0);
        wr(OFS_CONTROL, 32'h1, RESP_OKAY);
        repeat (5) @(posedge sys_clk);
        pulse(4'h8, e[2]);
        cmp(34'(seen), 34'hf);
        test_done();
    end
endmodule : tb
`default_nettype wire

// ### rtl/ctm_channel_mapping.sv
// Cross-trigger channel mapping: AXI4-Lite registers, pulse generation, input mapping
`timescale 1ns/1ns
`default_nettype none

module ctm_channel_mapping
    import ctm_pkg::*;
#(
    parameter int unsigned NUM_CHAN = CHAN_W
) (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    // AXI4-Lite write address
    input  wire logic [ctm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                s_axi_awprot,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [ctm_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ctm_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                s_axi_arprot,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    // AXI4-Lite read data
    output logic [ctm_pkg::DATA_W-1:0]     s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // Trigger inputs from the core, asynchronous
    input  wire logic [ctm_pkg::TRIG_W-1:0] triggerIn,
    // Channel events to the cross trigger matrix
    output logic [NUM_CHAN-1:0]            channelEvent
);

    import ctm_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic                globalMappingEnable;
    logic [NUM_CHAN-1:0] inputChannelEnable [TRIG_W];
    logic [NUM_CHAN-1:0] pulseChannelBits;
    logic [TRIG_W-1:0]   trigMeta;
    logic [TRIG_W-1:0]   trigSync;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic                awHeld;
    logic                wHeld;
    logic [ADDR_W-1:0]   awAddr;
    logic [DATA_W-1:0]   wData;
    logic [3:0]          wStrb;
    logic                doWrite;
    logic [ADDR_W-1:0]   wrAddr;
    logic [DATA_W-1:0]   wrData;
    logic [3:0]          wrStrb;
    logic                wrHit;

    // Address and data may arrive in either order
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;

    assign wrAddr  = awHeld ? awAddr : s_axi_awaddr;
    assign wrData  = wHeld ? wData : s_axi_wdata;
    assign wrStrb  = wHeld ? wStrb : s_axi_wstrb;
    assign doWrite = (awHeld || (s_axi_awvalid && s_axi_awready))
                  && (wHeld || (s_axi_wvalid && s_axi_wready));

    always_comb begin
        unique case (wrAddr)
            OFS_CONTROL,
            OFS_PULSE,
            OFS_INEN0,
            OFS_INEN1,
            OFS_INEN2,
            OFS_STATUS: wrHit = 1'b1;
            default:    wrHit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            awHeld <= 1'b0;
            awAddr <= '0;
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wHeld <= 1'b0;
            wData <= '0;
            wStrb <= '0;
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register updates
    // ------------------------------------------------------------
    // Only byte lane 0 carries live bits; upper lanes are ignored
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            globalMappingEnable <= GLB_RESET;
        end else if (doWrite && wrStrb[0] && wrAddr == OFS_CONTROL) begin
            globalMappingEnable <= wrData[GLB_EN_BIT];
        end
    end

    // Single-cycle strobe; no software clear needed
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            pulseChannelBits <= '0;
        end else if (doWrite && wrStrb[0] && wrAddr == OFS_PULSE) begin
            pulseChannelBits <= wrData[NUM_CHAN-1:0];
        end else begin
            pulseChannelBits <= '0;
        end
    end

    genvar t;
    generate
        for (t = 0; t < TRIG_W; t++) begin : g_inen
            // Enable registers sit at a fixed stride taken from the map
            localparam logic [ADDR_W-1:0] OFS = ADDR_W'(OFS_INEN0 + (OFS_INEN1 - OFS_INEN0) * t);
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    inputChannelEnable[t] <= INEN_RESET;
                end else if (doWrite && wrStrb[0] && wrAddr == OFS) begin
                    inputChannelEnable[t] <= wrData[NUM_CHAN-1:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic [DATA_W-1:0] next_rdata;
    logic              rdHit;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        next_rdata = '0;
        rdHit      = 1'b1;
        unique case (s_axi_araddr)
            OFS_CONTROL: next_rdata[GLB_EN_BIT] = globalMappingEnable;
            OFS_PULSE:   next_rdata = '0;  // Write-only, reads zero
            OFS_INEN0:   next_rdata[NUM_CHAN-1:0] = inputChannelEnable[0];
            OFS_INEN1:   next_rdata[NUM_CHAN-1:0] = inputChannelEnable[1];
            OFS_INEN2:   next_rdata[NUM_CHAN-1:0] = inputChannelEnable[2];
            OFS_STATUS:  next_rdata[NUM_CHAN-1:0] = channelEvent;
            default:     rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Trigger synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            trigMeta <= '0;
            trigSync <= '0;
        end else begin
            trigMeta <= triggerIn;
            trigSync <= trigMeta;
        end
    end

    // ------------------------------------------------------------
    // Channel event mapping
    // ------------------------------------------------------------
    // Stretching for a slow matrix is left to the handshake outside
    ctm_event_map #(
        .NUM_CHAN            (NUM_CHAN)
    ) u_map (
        .sys_clk             (sys_clk),
        .rst_b               (rst_b),
        .globalMappingEnable (globalMappingEnable),
        .inputChannelEnable  (inputChannelEnable),
        .pulseChannelBits    (pulseChannelBits),
        .triggerIn           (trigSync),
        .channelEvent        (channelEvent)
    );

endmodule : ctm_channel_mapping
`default_nettype wire

// ### rtl/ctm_event_map.sv
// Combines trigger inputs and software pulses into channel events
`timescale 1ns/1ns
`default_nettype none

module ctm_event_map
    import ctm_pkg::*;
#(
    parameter int unsigned NUM_CHAN = CHAN_W
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    // Controls
    input  wire logic                globalMappingEnable,
    input  wire logic [NUM_CHAN-1:0] inputChannelEnable [TRIG_W],
    input  wire logic [NUM_CHAN-1:0] pulseChannelBits,
    // Trigger inputs, already synchronised
    input  wire logic [TRIG_W-1:0]   triggerIn,
    // Channel events
    output logic      [NUM_CHAN-1:0] channelEvent
);

    logic [NUM_CHAN-1:0] next_channelEvent;

    // Per-channel OR of enabled inputs plus software pulses
    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            logic mapped;
            assign mapped = (triggerIn[0] & inputChannelEnable[0][c])
                          | (triggerIn[1] & inputChannelEnable[1][c])
                          | (triggerIn[2] & inputChannelEnable[2][c]);
            // Pulses bypass enables; gate only the mapped path
            assign next_channelEvent[c] = (globalMappingEnable & mapped)
                                        | pulseChannelBits[c];
        end
    endgenerate

    // Registered so the event is a clean flop output
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            channelEvent <= '0;
        end else begin
            channelEvent <= next_channelEvent;
        end
    end

endmodule : ctm_event_map
`default_nettype wire

// ### rtl/ctm_pkg.sv
// Package: register map, field layout and reset values for the channel mapping block
package ctm_pkg;

    localparam int unsigned CHAN_W      = 4;
    localparam int unsigned TRIG_W      = 3;
    localparam int unsigned ADDR_W      = 6;
    localparam int unsigned DATA_W      = 32;

    // Byte offsets of the registers
    localparam logic [5:0] OFS_CONTROL  = 6'h00;
    localparam logic [5:0] OFS_PULSE    = 6'h04;
    localparam logic [5:0] OFS_INEN0    = 6'h08;
    localparam logic [5:0] OFS_INEN1    = 6'h0c;
    localparam logic [5:0] OFS_INEN2    = 6'h10;
    localparam logic [5:0] OFS_STATUS   = 6'h14;

    // Field positions
    localparam int unsigned GLB_EN_BIT  = 0;

    // Reset values
    localparam logic [3:0] INEN_RESET   = 4'h0;
    localparam logic       GLB_RESET    = 1'b0;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

endpackage : ctm_pkg
